// >>> rtl/edge_sampler.sv
// Two-flop synchroniser plus one sample stage and edge classifier for one capture input
`timescale 1ns/1ps
module edge_sampler (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic sync1; // First synchroniser flop, read only by sync2
	logic sync2; // Current sample
	logic prev; // Previous sample

	// Sample once per rising bus clock edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// Compare consecutive samples
	assign rise = sync2 & ~prev;
	assign fall = ~sync2 & prev;
endmodule

// >>> rtl/timer_count_input_control.sv
// Count-source selection and capture-clear control for a 32-bit counter/timer
`timescale 1ns/1ps
`include "tmr_consts.svh"

// Functional notes
// - Counter mode samples selected input every clock
// - Consecutive samples classify rise, fall, either, none
// - Counter increments only on selected event
// - Mode zero: prescaler drives timer counter
// - Modes one-three count rise, fall, both
// - Input select picks input zero-two; three reserved
// - Clear enable zeroes timer and prescaler on edge
// - Edge select decodes channel and polarity
// - Edge select ignored when disabled; six-seven reserved
// - Upper control bits reserved, write zero
module timer_count_input_control #(
	parameter int COUNT_WIDTH = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] capture_input,
	output logic [COUNT_WIDTH-1:0] timer_counter_value,
	output logic [COUNT_WIDTH-1:0] prescale_counter,
	output logic count_pulse
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [`CSC_WIDTH-1:0] count_source_control; // Mode, input, clear control
	logic [COUNT_WIDTH-1:0] prescale_reg; // Prescale limit

	// Decoded control fields
	logic [1:0] count_mode_field; // Timer or edge-count mode
	logic [1:0] count_input_select; // Counted capture input
	logic capture_clear_enable; // Clear on edge allowed
	logic [2:0] clear_edge_select; // Channel and polarity of the clear

	// Edge detection and event matching
	logic [2:0] rise; // Per-input rising edge
	logic [2:0] fall; // Per-input falling edge
	logic sel_rise; // Rising edge on counted input
	logic sel_fall; // Falling edge on counted input
	tmr_pkg::edge_event_t sel_event; // Classified event
	logic count_hit; // Counter-mode increment
	logic clear_hit; // Capture-clear event
	logic clear_pend; // Clear to apply next edge

	// Bus decode
	logic wr_en; // Write commits on this edge
	logic rd_en; // Read setup, loads prdata
	logic addr_ok; // Address maps to a register

	// Split the control register into its fields
	assign count_mode_field = count_source_control[`CSC_MODE_LSB +: 2];
	assign count_input_select = count_source_control[`CSC_SEL_LSB +: 2];
	assign capture_clear_enable = count_source_control[`CSC_CCEN_BIT];
	assign clear_edge_select = count_source_control[`CSC_CCSEL_LSB +: 3];

	// ----------------------------------------------------------------
	// Input sampling
	// ----------------------------------------------------------------
	// One sampler per capture input; both counting and clear share it
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CAPTURE_INPUTS; gi++) begin : g_samp
			edge_sampler u_samp (
				.clk(clk),
				.rstn(rstn),
				.pin(capture_input[gi]),
				.rise(rise[gi]),
				.fall(fall[gi])
			);
		end
	endgenerate

	// Select counted input; reserved select counts nothing
	always_comb begin
		sel_rise = 1'b0;
		sel_fall = 1'b0;
		case (count_input_select)
			2'h0: begin
				sel_rise = rise[0];
				sel_fall = fall[0];
			end
			2'h1: begin
				sel_rise = rise[1];
				sel_fall = fall[1];
			end
			2'h2: begin
				sel_rise = rise[2];
				sel_fall = fall[2];
			end
			default: begin
				sel_rise = 1'b0;
				sel_fall = 1'b0;
			end
		endcase
	end

	// Classify one event from the sample pair
	always_comb begin
		if (sel_rise) begin
			sel_event = tmr_pkg::EV_RISE;
		end else if (sel_fall) begin
			sel_event = tmr_pkg::EV_FALL;
		end else begin
			sel_event = tmr_pkg::EV_NONE;
		end
	end

	// Match event against mode
	always_comb begin
		case (tmr_pkg::count_mode_t'(count_mode_field))
			tmr_pkg::MODE_RISE: count_hit = (sel_event == tmr_pkg::EV_RISE);
			tmr_pkg::MODE_FALL: count_hit = (sel_event == tmr_pkg::EV_FALL);
			tmr_pkg::MODE_BOTH: count_hit = (sel_event != tmr_pkg::EV_NONE);
			default: count_hit = 1'b0;
		endcase
	end

	// Clear edge decode; reserved codes never clear
	always_comb begin
		case (clear_edge_select)
			3'h0: clear_hit = rise[0];
			3'h1: clear_hit = fall[0];
			3'h2: clear_hit = rise[1];
			3'h3: clear_hit = fall[1];
			3'h4: clear_hit = rise[2];
			3'h5: clear_hit = fall[2];
			default: clear_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	// Register the clear so it lands on the following edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			clear_pend <= 1'b0;
		end else begin
			clear_pend <= capture_clear_enable & clear_hit;
		end
	end

	// Prescaler and timer counter; clear beats counting
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prescale_counter <= '0;
			timer_counter_value <= '0;
			count_pulse <= 1'b0;
		end else if (clear_pend) begin
			prescale_counter <= '0;
			timer_counter_value <= '0;
			count_pulse <= 1'b0;
		end else if (wr_en && paddr == `ADDR_TIMER_COUNT) begin
			timer_counter_value <= pwdata[COUNT_WIDTH-1:0];
			count_pulse <= 1'b0;
		end else if (count_mode_field == tmr_pkg::MODE_TIMER) begin
			if (prescale_counter == prescale_reg) begin
				prescale_counter <= '0;
				timer_counter_value <= timer_counter_value + 1'b1;
				count_pulse <= 1'b1;
			end else begin
				prescale_counter <= prescale_counter + 1'b1;
				count_pulse <= 1'b0;
			end
		end else if (count_hit) begin
			timer_counter_value <= timer_counter_value + 1'b1;
			count_pulse <= 1'b1;
		end else begin
			count_pulse <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; unmapped addresses flag an error
	assign addr_ok = (paddr == `ADDR_COUNT_SOURCE_CONTROL) || (paddr == `ADDR_TIMER_COUNT) ||
		(paddr == `ADDR_PRESCALE_REG) || (paddr == `ADDR_PRESCALE_CNT);
	// Never stretches a transfer, so the master needs no wait logic
	assign pready = 1'b1;
	// Error only in the access phase, where the master samples it
	assign pslverr = psel & penable & ~addr_ok;
	// Writes land on the access edge; unmapped writes are dropped
	assign wr_en = psel & penable & pwrite & addr_ok;
	// Reads load in setup so data stands through the access phase
	assign rd_en = psel & ~penable & ~pwrite;

	// Control register writes; upper bits are not stored
	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_source_control <= `CSC_RESET;
			prescale_reg <= '0;
		end else if (wr_en) begin
			if (paddr == `ADDR_COUNT_SOURCE_CONTROL) begin
				count_source_control <= pwdata[`CSC_WIDTH-1:0];
			end else if (paddr == `ADDR_PRESCALE_REG) begin
				prescale_reg <= pwdata[COUNT_WIDTH-1:0];
			end
		end
	end

	// Read data captured in setup phase, valid in access phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prdata <= 32'h0;
		end else if (rd_en) begin
			case (paddr)
				`ADDR_COUNT_SOURCE_CONTROL: prdata <= {24'h0, count_source_control};
				`ADDR_TIMER_COUNT: prdata <= 32'(timer_counter_value);
				`ADDR_PRESCALE_REG: prdata <= 32'(prescale_reg);
				`ADDR_PRESCALE_CNT: prdata <= 32'(prescale_counter);
				default: prdata <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Counter mode: a selected event adds exactly one
	// Bus writes are excluded, since a timer-count load outranks counting
	AST_COUNT_INC: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field != 2'h0 && count_hit && !clear_pend && !wr_en
		|=> timer_counter_value == $past(timer_counter_value) + 1'b1)
		else $error("Counter missed a counted edge");

	// Counter mode: no event leaves the count alone
	// Bus writes are excluded, they may load any value
	AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field != 2'h0 && !count_hit && !clear_pend && !wr_en
		|=> $stable(timer_counter_value))
		else $error("Counter moved without event");

	// Counter mode freezes the prescaler; only a clear moves it
	AST_COUNTER_PC_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field != 2'h0 && !clear_pend |=> $stable(prescale_counter))
		else $error("Prescaler moved in counter mode");

	// Each count pulse stands beside a one-step increment
	// Bus loads and clears never pulse, so software sees real ticks only
	AST_PULSE_STEP: assert property (@(posedge clk) disable iff (!rstn)
		count_pulse |-> timer_counter_value == $past(timer_counter_value) + 1'b1)
		else $error("Count pulse without a one-step increment");

	// Rising mode ignores falling edges
	AST_RISE_MODE: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h1 && sel_fall |-> !count_hit)
		else $error("Rising mode counted a falling edge");

	// Falling mode ignores rising edges
	AST_FALL_MODE: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h2 && sel_rise |-> !count_hit)
		else $error("Falling mode counted a rising edge");

	// Dual-edge mode counts every level change once
	AST_BOTH_MODE: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h3 && (sel_rise || sel_fall) |-> count_hit)
		else $error("Dual-edge mode missed an edge");

	// One sample pair yields at most one edge
	// Otherwise dual-edge mode could count a single change twice
	AST_EVENT_ONE: assert property (@(posedge clk) disable iff (!rstn)
		!(sel_rise && sel_fall))
		else $error("Two events from one sample pair");

	// Reserved input select counts nothing, whatever the pins do
	AST_SEL_RESERVED: assert property (@(posedge clk) disable iff (!rstn)
		count_input_select == 2'h3 |-> !count_hit)
		else $error("Reserved input select counted");

	// Timer mode: prescaler wrap ticks the counter
	// The pulse proves the tick came from the wrap, not from a bus load
	AST_TIMER_PRESCALE: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h0 && !clear_pend && !wr_en && prescale_counter == prescale_reg
		|=> prescale_counter == '0 && count_pulse)
		else $error("Prescale wrap did not tick timer");

	// Timer mode: below its limit the prescaler steps by one
	// A timer-count write stalls it for that edge, hence the exclusion
	AST_PRESCALE_STEP: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h0 && !clear_pend && !wr_en && prescale_counter != prescale_reg
		|=> prescale_counter == $past(prescale_counter) + 1'b1)
		else $error("Prescaler did not advance");

	// Timer mode: the counter waits while the prescaler climbs
	AST_TIMER_WAIT: assert property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h0 && !clear_pend && !wr_en && prescale_counter != prescale_reg
		|=> $stable(timer_counter_value))
		else $error("Timer moved before the prescaler wrapped");

	// Enabled clear edge zeroes both counters two edges on:
	// one edge to register the clear, one to apply it
	AST_CLEAR_NEXT: assert property (@(posedge clk) disable iff (!rstn)
		capture_clear_enable && clear_hit
		|-> ##2 timer_counter_value == '0 && prescale_counter == '0)
		else $error("Counters not cleared after clear edge");

	// A registered clear beats both a bus write and counting
	// Measurements would start from a wrong base otherwise
	AST_CLEAR_WINS: assert property (@(posedge clk) disable iff (!rstn)
		clear_pend |=> timer_counter_value == '0 && prescale_counter == '0)
		else $error("Pending clear lost to another update");

	// Disabled clear never arms, whatever the edge select holds
	// Software may park any select value while the enable is low
	AST_NO_CLEAR_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
		!capture_clear_enable |=> !clear_pend)
		else $error("Clear raised while disabled");

	// Reserved edge selects never arm a clear
	// Checked on the registered clear, so the whole path is covered
	AST_RESERVED_SEL: assert property (@(posedge clk) disable iff (!rstn)
		clear_edge_select[2:1] == 2'h3 |=> !clear_pend)
		else $error("Reserved edge select cleared");

	// Reserved control bits always read back as zero
	AST_CTRL_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
		rd_en && paddr == `ADDR_COUNT_SOURCE_CONTROL |=> prdata[31:8] == 24'h0)
		else $error("Reserved control bits read nonzero");

	// ----------------------------------------------------------------
	// Coverage of the main scenarios
	// ----------------------------------------------------------------
	COV_RISE_COUNT: cover property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h1 && count_hit);
	COV_BOTH_COUNT: cover property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h3 && count_hit);
	COV_FALL_COUNT: cover property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h2 && count_hit);
	COV_CLEAR: cover property (@(posedge clk) disable iff (!rstn) clear_pend);
	COV_TIMER_WRAP: cover property (@(posedge clk) disable iff (!rstn)
		count_mode_field == 2'h0 && count_pulse);
endmodule

// >>> rtl/tmr_consts.svh
// Register offsets, field positions and reset values of the count-input timer block
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_TIMER_COUNT 12'h008
`define ADDR_PRESCALE_REG 12'h00c
`define ADDR_PRESCALE_CNT 12'h010
`define ADDR_COUNT_SOURCE_CONTROL 12'h070
// ----------------------------------------------------------------
// Field positions of count_source_control
// ----------------------------------------------------------------
`define CSC_MODE_LSB 0
`define CSC_SEL_LSB 2
`define CSC_CCEN_BIT 4
`define CSC_CCSEL_LSB 5
`define CSC_WIDTH 8
`define CSC_RESET 8'h00
`define CSC_SEL_RESERVED 2'h3
`define NUM_CAPTURE_INPUTS 3
`endif

// >>> rtl/tmr_pkg.sv
// Types shared by the count-input timer block
package tmr_pkg;
	// Detected event on a sampled input
	typedef enum logic [1:0] {
		EV_NONE,
		EV_RISE,
		EV_FALL
	} edge_event_t;
	// Count mode encodings
	typedef enum logic [1:0] {
		MODE_TIMER = 2'h0,
		MODE_RISE = 2'h1,
		MODE_FALL = 2'h2,
		MODE_BOTH = 2'h3
	} count_mode_t;
endpackage

// >>> test/cap_source_model.sv
// Behavioural source of the three capture input pins
`timescale 1ns/1ps
module cap_source_model #(
	parameter int HOLD = 4
) (
	input wire logic clk,
	output logic [2:0] capture_input
);
	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// All pins idle low until a scenario moves them
	initial begin
		capture_input = 3'h0;
	end
	// Changes one pin just after an edge, then holds it for HOLD cycles
	// so the level never toggles faster than half the bus clock
	task automatic drive(input int ch, input logic lv);
		@(posedge clk);
		capture_input[ch] <= lv;
		repeat (HOLD) @(posedge clk);
	endtask
endmodule

// >>> test/timer_count_input_control_tb_top.sv
// Self-checking bench for the count-input timer block
`timescale 1ns/1ps
`include "tmr_consts.svh"
module timer_count_input_control_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk = 1'b0; // 25 MHz bus clock
	logic rstn = 1'b0; // Active-low synchronous reset
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, base, timer_counter_value, prescale_counter;
	logic pready, pslverr, count_pulse, err;
	logic [2:0] capture_input; // Driven by the pin model
	int fails = 0;
	int checks_done = 0;
	// Clock generator
	initial begin
		forever #20 clk = ~clk;
	end
	timer_count_input_control u_timer_count_input_control (.clk(clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_input(capture_input),
		.timer_counter_value(timer_counter_value), .prescale_counter(prescale_counter),
		.count_pulse(count_pulse));
	cap_source_model u_cap_source_model (.clk(clk), .capture_input(capture_input));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Word compare, four-state exact
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Lets the synchroniser and counters settle, sampling off the edge
	task automatic settle();
		repeat (8) @(negedge clk);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset value, unmapped access, field readback
	task automatic t_regs();
		apb(1'b0, `ADDR_COUNT_SOURCE_CONTROL, 32'h0);
		check(rd, 32'h0, "control reset");
		apb(1'b0, 12'h0f0, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped read");
		apb(1'b1, `ADDR_COUNT_SOURCE_CONTROL, 32'h000000a5);
		apb(1'b0, `ADDR_COUNT_SOURCE_CONTROL, 32'h0);
		check(rd, 32'h000000a5, "control readback");
	endtask
	// Timer mode with prescale 2: one count every three clocks
	task automatic t_timer();
		int pulses;
		apb(1'b1, `ADDR_PRESCALE_REG, 32'h2);
		apb(1'b0, `ADDR_PRESCALE_REG, 32'h0);
		check(rd, 32'h2, "prescale readback");
		apb(1'b1, `ADDR_COUNT_SOURCE_CONTROL, 32'h0);
		pulses = 0;
		@(negedge clk);
		base = timer_counter_value;
		// One pulse must stand beside every tick of the counter
		repeat (30) begin
			@(negedge clk);
			pulses += (count_pulse === 1'b1);
		end
		check(timer_counter_value - base, 32'd10, "timer rate");
		check(32'(pulses), 32'd10, "timer pulses");
	endtask
	// Every edge-count mode on every input select, with a distractor pin
	task automatic t_count();
		int ch;
		apb(1'b1, `ADDR_PRESCALE_REG, 32'h0);
		for (int m = 1; m < 4; m++) begin
			for (int s = 0; s < 4; s++) begin
				ch = s % 3;
				// No capture is armed on any input, the counted one included
				apb(1'b1, `ADDR_COUNT_SOURCE_CONTROL, 32'(m | (s << 2)));
				settle();
				base = timer_counter_value;
				u_cap_source_model.drive((ch + 1) % 3, 1'b1);
				u_cap_source_model.drive((ch + 1) % 3, 1'b0);
				u_cap_source_model.drive(ch, 1'b1);
				u_cap_source_model.drive(ch, 1'b0);
				settle();
				check(timer_counter_value - base, (s == 3) ? 32'd0 : ((m == 3) ? 32'd2 : 32'd1),
					"edge count");
			end
		end
	endtask
	// Clear on each edge select, reserved selects and disabled clear
	task automatic t_clear();
		int e;
		int ch;
		logic en;
		apb(1'b1, `ADDR_PRESCALE_REG, 32'hffffffff);
		for (int k = 0; k < 9; k++) begin
			e = k % 8;
			en = (k < 8);
			ch = (e < 6) ? e / 2 : e - 6;
			apb(1'b1, `ADDR_COUNT_SOURCE_CONTROL, 32'((e << 5) | (en << 4)));
			apb(1'b1, `ADDR_TIMER_COUNT, 32'h55);
			u_cap_source_model.drive(ch, 1'b1);
			settle();
			check(timer_counter_value, (en && e < 6 && e % 2 == 0) ? 32'h0 : 32'h55,
				"clear rise");
			// A cleared prescaler has climbed exactly seven steps by now
			check(32'(prescale_counter == 32'd7), 32'(en && e < 6 && e % 2 == 0),
				"prescale clear rise");
			apb(1'b1, `ADDR_TIMER_COUNT, 32'h55);
			u_cap_source_model.drive(ch, 1'b0);
			settle();
			check(timer_counter_value, (en && e < 6 && e % 2 == 1) ? 32'h0 : 32'h55,
				"clear fall");
			check(32'(prescale_counter == 32'd7), 32'(en && e < 6 && e % 2 == 1),
				"prescale clear fall");
		end
	endtask
	// ----------------------------------------------------------------
	// Sequence and verdict
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("Checks %0d, failures %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_timer();
		t_count();
		t_clear();
		give_verdict();
	end
	// Watchdog well past the expected run of about 850 cycles
	initial begin
		#400000;
		fails++;
		give_verdict();
	end
endmodule
